// *** hdl/ctcl_map.svh ***
// constants of the coupler tune control logic: timing, reset values, bits
// assumes a 10 MHz clock and a synchronous sampling of every transceiver and servo board pin
`ifndef CTCL_MAP_SVH
`define CTCL_MAP_SVH

`define CTCL_CLK_HZ          10000000
// times in milliseconds
`define CTCL_TUNE_TIMEOUT_MS 5000
`define CTCL_PAD_REINSERT_MS 5
`define CTCL_QUAL_MS         2
`define CTCL_CYC_PER_MS      (`CTCL_CLK_HZ / 1000)

// reset values of the latches
`define CTCL_FAULT_RST       1'b1
`define CTCL_TUNING_RST      1'b0
`define CTCL_PAD_RST         1'b0

// bit positions of the synchronised input vector
`define CTCL_IN_W            8
`define CTCL_B_TUNE          0
`define CTCL_B_RF            1
`define CTCL_B_REFL          2
`define CTCL_B_CHG           3
`define CTCL_B_NOM           4
`define CTCL_B_LMAX_N        5
`define CTCL_B_FORCE         6
`define CTCL_B_MATCH_N       7
// idle levels of the inputs: active-low lines idle high
`define CTCL_SYNC_RST        8'ha0

`endif

// *** hdl/ctcl_pkg.sv ***
// types of the coupler tune control logic
// assumes ctcl_map.svh supplies the numeric constants
package ctcl_pkg;

	// inputs from the transceiver and the detectors
	typedef struct packed {
		logic tune_request;
		logic rf_present;
		logic refl_above;
		logic channel_change_supply;
		logic nominal_supply_on;
	} ctcl_xcvr_t;

	// lines from the servo board
	typedef struct packed {
		logic ind_at_max_n_i;
		logic ind_force_to_max;
		logic match_found_n;
	} ctcl_servo_in_t;

	// front panel lamps
	typedef struct packed {
		logic tuning;
		logic ready;
		logic fault;
	} ctcl_lamp_t;

endpackage

// *** hdl/ctcl_sync.sv ***
// two-stage synchroniser, one chain per input bit
// assumes inputs may change at any time relative to clk
`timescale 1ns/1ps
module ctcl_sync #(
	parameter int             W       = 8,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	import ctcl_pkg::*;

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} ctcl_sync_st_t;

	ctcl_sync_st_t st_r;
	ctcl_sync_st_t st_nxt;

	// first stage feeds only the second stage
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_comb begin
				st_nxt.meta[i]   = d[i];
				st_nxt.stable[i] = st_r.meta[i];
			end
		end
	endgenerate

	// both stages settle to the idle levels under reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= {RST_VAL, RST_VAL};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.stable;
endmodule

// *** hdl/ctcl_timer.sv ***
// saturating delay timer with dominant clear and a registered done level
// assumes LIMIT of at least one cycle
`timescale 1ns/1ps
module ctcl_timer #(
	parameter int unsigned LIMIT = 16,
	parameter int          W     = $clog2(LIMIT + 1)
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic clr,
	input  wire logic en,
	output logic      done
);
	import ctcl_pkg::*;

	localparam logic [W-1:0] LIM = LIMIT[W-1:0];

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         done;
	} ctcl_timer_st_t;

	ctcl_timer_st_t st_r;
	ctcl_timer_st_t st_nxt;

	// clear beats counting, so a discharge never loses to a late edge
	always_comb begin
		st_nxt = st_r;
		if (clr) begin
			st_nxt.cnt = '0;
		end else if (en && st_r.cnt != LIM) begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
		st_nxt.done = (st_nxt.cnt == LIM);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign done = st_r.done;
endmodule

// *** hdl/ctcl_top.sv ***
// control logic of the antenna coupler: tune, fault, ready and pad latches
// assumes one 10 MHz clock; transceiver and servo board lines are plain pins
`timescale 1ns/1ps
`include "ctcl_map.svh"
module ctcl_top #(
	parameter int unsigned TIMEOUT_CYCLES  =
		`CTCL_TUNE_TIMEOUT_MS * `CTCL_CYC_PER_MS,
	parameter int unsigned REINSERT_CYCLES =
		`CTCL_PAD_REINSERT_MS * `CTCL_CYC_PER_MS,
	parameter int unsigned QUAL_CYCLES     =
		`CTCL_QUAL_MS * `CTCL_CYC_PER_MS
) (
	input  wire logic                clk,
	input  wire logic                rst,
	input  ctcl_pkg::ctcl_xcvr_t     xcvr,
	input  ctcl_pkg::ctcl_servo_in_t servo,
	input  wire logic                opt_nominal_en,
	output logic                     cap_home_request_n,
	output logic                     ind_home_request_n,
	output logic                     ind_at_max_n_o,
	output logic                     ind_at_max_n_oe,
	output logic                     pad_relay,
	output ctcl_pkg::ctcl_lamp_t     lamps
);
	import ctcl_pkg::*;

	// every latch and edge memory of the block
	typedef struct packed {
		logic tuning;
		logic fault;
		logic ready;
		logic pad_in;
		logic home;
		logic lmax_pull;
		logic tune_prev;
		logic chg_prev;
		logic nom_prev;
	} ctcl_st_t;

	ctcl_st_t st_r;
	ctcl_st_t st_nxt;

	logic [`CTCL_IN_W-1:0] raw_in;
	logic [`CTCL_IN_W-1:0] syn;

	logic tune_lvl;
	logic rf;
	logic refl_hi;
	logic chg_lvl;
	logic nom_lvl;
	logic lmax_n;
	logic force_max;
	logic match_n;

	logic start;
	logic chg_rise;
	logic nom_rise;
	logic tmo_done;
	logic tmo_evt;
	logic qual_done;
	logic success;
	logic reins_done;
	logic opt_evt;
	logic pad_set;
	logic pad_release;

	logic tmo_clr;
	logic qual_clr;
	logic qual_en;
	logic reins_clr;
	logic reins_en;

	// gather the pins in one vector for the synchroniser
	always_comb begin
		raw_in                   = '0;
		raw_in[`CTCL_B_TUNE]     = xcvr.tune_request;
		raw_in[`CTCL_B_RF]       = xcvr.rf_present;
		raw_in[`CTCL_B_REFL]     = xcvr.refl_above;
		raw_in[`CTCL_B_CHG]      = xcvr.channel_change_supply;
		raw_in[`CTCL_B_NOM]      = xcvr.nominal_supply_on;
		raw_in[`CTCL_B_LMAX_N]   = servo.ind_at_max_n_i;
		raw_in[`CTCL_B_FORCE]    = servo.ind_force_to_max;
		raw_in[`CTCL_B_MATCH_N]  = servo.match_found_n;
	end

	// detector outputs are slow analogue levels, two flops are enough
	ctcl_sync #(
		.W       (`CTCL_IN_W),
		.RST_VAL (`CTCL_SYNC_RST)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   (raw_in),
		.q   (syn)
	);

	// named views of the synchronised inputs
	assign tune_lvl  = syn[`CTCL_B_TUNE];
	assign rf        = syn[`CTCL_B_RF];
	assign refl_hi   = syn[`CTCL_B_REFL];
	assign chg_lvl   = syn[`CTCL_B_CHG];
	assign nom_lvl   = syn[`CTCL_B_NOM];
	assign lmax_n    = syn[`CTCL_B_LMAX_N];
	assign force_max = syn[`CTCL_B_FORCE];
	assign match_n   = syn[`CTCL_B_MATCH_N];

	// edges: only rising edges count, a falling supply is no event
	// the edge memories reset to the idle levels, so no false edge
	assign start    = tune_lvl & ~st_r.tune_prev;
	assign chg_rise = chg_lvl & ~st_r.chg_prev;
	assign nom_rise = nom_lvl & ~st_r.nom_prev;

	// tuning timeout: runs only inside a cycle, dumped when it ends
	assign tmo_clr = ~st_r.tuning;

	// saturates at the limit; a repeat request does not re-arm it
	ctcl_timer #(
		.LIMIT (TIMEOUT_CYCLES)
	) u_timeout (
		.clk  (clk),
		.rst  (rst),
		.clr  (tmo_clr),
		.en   (st_r.tuning),
		.done (tmo_done)
	);

	// the done level stays up one cycle after tuning drops; gate it
	assign tmo_evt = tmo_done & st_r.tuning;

	// below-threshold qualification: reflected power must stay low
	// for the whole interval before the cycle may end
	always_comb begin
		qual_clr = 1'b0;
		if (refl_hi) begin
			qual_clr = 1'b1;
		end
		if (tune_lvl) begin
			qual_clr = 1'b1;
		end
		if (!st_r.tuning) begin
			qual_clr = 1'b1;
		end
	end
	assign qual_en = st_r.tuning & ~refl_hi;

	// its length is how long the match must hold before the end
	ctcl_timer #(
		.LIMIT (QUAL_CYCLES)
	) u_qual (
		.clk  (clk),
		.rst  (rst),
		.clr  (qual_clr),
		.en   (qual_en),
		.done (qual_done)
	);

	// normal end: RF present and reflected power qualified low
	assign success = st_r.tuning & rf & qual_done & ~refl_hi & ~tune_lvl;

	// pad re-insertion: if the pad is out too long without a match,
	// switch it back in so the transmitter never sees an open or short
	always_comb begin
		reins_clr = st_r.pad_in | ~st_r.tuning;
		if (!match_n) begin
			reins_clr = 1'b1;
		end
	end
	assign reins_en = st_r.tuning & ~st_r.pad_in;

	// counts only while the pad is out inside a cycle
	ctcl_timer #(
		.LIMIT (REINSERT_CYCLES)
	) u_reinsert (
		.clk  (clk),
		.rst  (rst),
		.clr  (reins_clr),
		.en   (reins_en),
		.done (reins_done)
	);

	// optional nominal-supply abort, strapped off in the base build
	// tie opt_nominal_en low unless the supply sense is wired
	assign opt_evt = opt_nominal_en & nom_rise & st_r.tuning;

	// every reason to pull the pad in; pulling in wins over release
	always_comb begin
		pad_set = 1'b0;
		if (start) begin
			pad_set = 1'b1;
		end
		if (st_r.tuning && !rf) begin
			pad_set = 1'b1;
		end
		if (!st_r.tuning && refl_hi) begin
			pad_set = 1'b1;
		end
		if (!lmax_n) begin
			pad_set = 1'b1;
		end
		if (reins_done && st_r.tuning) begin
			pad_set = 1'b1;
		end
	end

	// out again only with rf in and reflection low; any set wins
	assign pad_release = rf & ~refl_hi;

	// latch updates
	always_comb begin
		st_nxt           = st_r;
		st_nxt.tune_prev = tune_lvl;
		st_nxt.chg_prev  = chg_lvl;
		st_nxt.nom_prev  = nom_lvl;

		// tuning latch: a new request wins over any end condition
		if (start) begin
			st_nxt.tuning = 1'b1;
		end else if (tmo_evt) begin
			st_nxt.tuning = 1'b0;
		end else if (opt_evt) begin
			st_nxt.tuning = 1'b0;
		end else if (success) begin
			st_nxt.tuning = 1'b0;
		end

		// fault latch: setting events first, tuning then forces it clear
		if (chg_rise) begin
			st_nxt.fault = 1'b1;
		end
		if (!st_r.tuning && !start && refl_hi) begin
			st_nxt.fault = 1'b1;
		end
		if (success) begin
			st_nxt.fault = 1'b0;
		end
		if (tmo_evt) begin
			st_nxt.fault = 1'b1;
		end
		if (opt_evt) begin
			st_nxt.fault = 1'b1;
		end
		// a start that beat the end keeps tuning, so the lamp stays dark
		if (st_nxt.tuning) begin
			st_nxt.fault = 1'b0;
		end

		// ready lamp: only a clean end lights it, any fault kills it
		if (start || st_nxt.fault) begin
			st_nxt.ready = 1'b0;
		end else if (success) begin
			st_nxt.ready = 1'b1;
		end

		// home requests follow the tune pulse, released on a clean end
		if (start) begin
			st_nxt.home = 1'b1;
		end else if (!tune_lvl || success) begin
			st_nxt.home = 1'b0;
		end

		// pad latch
		if (pad_set) begin
			st_nxt.pad_in = 1'b1;
		end else if (pad_release) begin
			st_nxt.pad_in = 1'b0;
		end

		// max-line pull: held until the servo board drops its force
		if (tmo_evt && force_max) begin
			st_nxt.lmax_pull = 1'b1;
		end else if (!force_max) begin
			st_nxt.lmax_pull = 1'b0;
		end
	end

	// fault lamp is lit from power-up until a tune cycle starts
	// reset loads constants only; the edge memories come up at idle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r        <= '0;
			st_r.fault  <= `CTCL_FAULT_RST;
			st_r.tuning <= `CTCL_TUNING_RST;
			st_r.pad_in <= `CTCL_PAD_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// home lines go low together and are released together
	assign cap_home_request_n = ~st_r.home;
	assign ind_home_request_n = ~st_r.home;

	// open-drain max line: only ever pulled low, never driven high
	assign ind_at_max_n_o     = 1'b0;
	assign ind_at_max_n_oe    = st_r.lmax_pull;

	// pad relay and lamps straight from the latches
	assign pad_relay          = st_r.pad_in;
	assign lamps.tuning       = st_r.tuning;
	assign lamps.ready        = st_r.ready;
	assign lamps.fault        = st_r.fault;
endmodule

// *** test/ctcl_servo_model.sv ***
// servo board model: pulled-up max line, force latch, match pulse
// assumes the bench commands the model on the falling edge
`timescale 1ns/1ps
module ctcl_servo_model
	import ctcl_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                at_max,
	input  wire logic                force_set,
	input  wire logic                match,
	input  wire logic                pull_n_o,
	input  wire logic                pull_oe,
	output ctcl_pkg::ctcl_servo_in_t servo
);
	logic line_n;
	logic force_r = 1'b0;
	// wired line: limit switch or the block pulls it, else the pull-up
	assign line_n = !(at_max || (pull_oe && !pull_n_o));
	// force runs until the max line goes low, as on the real board
	always_ff @(posedge clk) begin
		if (!line_n)
			force_r <= 1'b0;
		else if (force_set)
			force_r <= 1'b1;
	end
	assign servo.ind_at_max_n_i   = line_n;
	assign servo.ind_force_to_max = force_r;
	assign servo.match_found_n    = !match;
endmodule

// *** test/ctcl_top_properties.sv ***
// checker on the ports of ctcl_top
// assumes two cycles of input synchroniser latency plus one for the latches
`timescale 1ns/1ps
module ctcl_top_properties
	import ctcl_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = 200
) (
	input  wire logic                clk,
	input  wire logic                rst,
	input  ctcl_pkg::ctcl_xcvr_t     xcvr,
	input  ctcl_pkg::ctcl_servo_in_t servo,
	input  wire logic                opt_nominal_en,
	input  wire logic                cap_home_request_n,
	input  wire logic                ind_home_request_n,
	input  wire logic                ind_at_max_n_o,
	input  wire logic                ind_at_max_n_oe,
	input  wire logic                pad_relay,
	input  ctcl_pkg::ctcl_lamp_t     lamps
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [31:0] tune_cnt_r;
	// cycles spent tuning; bounds the timeout without long repetitions
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			tune_cnt_r <= '0;
		else
			tune_cnt_r <= lamps.tuning ? tune_cnt_r + 1 : '0;
	end
	sequence s_start;
		$rose(xcvr.tune_request);
	endsequence
	sequence s_timeout;
		$fell(lamps.tuning) && !lamps.ready;
	endsequence
	a_start_sets_tuning: assert property (s_start |-> ##[2:5] (lamps.tuning && pad_relay))
		else $error("start missed");
	a_start_home_low: assert property (s_start |-> ##[2:5] (!cap_home_request_n && !ind_home_request_n))
		else $error("home not driven");
	a_fault_off_tuning: assert property (lamps.tuning |-> !lamps.fault)
		else $error("fault lit while tuning");
	a_timeout_sets_fault: assert property (s_timeout |-> lamps.fault)
		else $error("timeout without fault");
	a_timeout_bound: assert property (tune_cnt_r <= TIMEOUT_CYCLES + 3)
		else $error("tuning outlived timeout");
	a_change_sets_fault: assert property ($rose(xcvr.channel_change_supply) && !lamps.tuning && !xcvr.tune_request |-> ##[2:5] lamps.fault)
		else $error("channel change missed");
	a_no_rf_pad: assert property ((lamps.tuning && !xcvr.rf_present) [*5] |-> pad_relay)
		else $error("pad out without rf");
	a_idle_refl_pad: assert property ((!lamps.tuning && xcvr.refl_above && !xcvr.tune_request) [*5] |-> pad_relay)
		else $error("pad out on reflection");
	a_at_max_pad: assert property ((!servo.ind_at_max_n_i) [*5] |-> pad_relay)
		else $error("pad out at max");
	a_force_pull_low: assert property (servo.ind_force_to_max [*5] ##1 s_timeout |-> ##[0:1] (ind_at_max_n_oe && !ind_at_max_n_o))
		else $error("max line not pulled");
	a_success_release: assert property ($fell(lamps.tuning) && !lamps.fault |-> ##[0:1] (lamps.ready && cap_home_request_n && ind_home_request_n))
		else $error("success not shown");
endmodule

// *** test/testbench.sv ***
// bench for ctcl_top with the servo board model
// assumes short timer parameters so a timeout takes a few hundred cycles
`timescale 1ns/1ps
module testbench;
	import ctcl_pkg::*;
	localparam int TO = 200;
	logic           clk, rst, opt_en, at_max, frc, match;
	logic           cap_n, ind_n, pull_n_o, pull_oe, pad;
	ctcl_xcvr_t     xcvr;
	ctcl_servo_in_t servo;
	ctcl_lamp_t     lamps;
	int             miscompares, samples_checked, cyc_cnt, n;
	ctcl_top #(.TIMEOUT_CYCLES(TO), .REINSERT_CYCLES(20), .QUAL_CYCLES(10))
	dut (.clk(clk), .rst(rst), .xcvr(xcvr), .servo(servo),
		.opt_nominal_en(opt_en), .cap_home_request_n(cap_n),
		.ind_home_request_n(ind_n), .ind_at_max_n_o(pull_n_o),
		.ind_at_max_n_oe(pull_oe), .pad_relay(pad), .lamps(lamps));
	ctcl_servo_model u_servo (.clk(clk), .at_max(at_max), .force_set(frc),
		.match(match), .pull_n_o(pull_n_o), .pull_oe(pull_oe), .servo(servo));
	task automatic chk(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t ns: check %0d", $time, samples_checked);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	// count cycles until the tuning lamp drops, bounded
	task automatic wait_end(input int lim);
		n = 0;
		while (lamps.tuning === 1'b1 && n < lim) begin
			cyc(1);
			n++;
		end
		chk(lamps.tuning, 1'b0);
	endtask
	task automatic final_report;
		if (miscompares == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// hang guard well above the planned run length
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 3000) begin
			miscompares++;
			final_report();
		end
	end
	initial begin
		xcvr = '0;
		{opt_en, at_max, frc, match} = '0;
		{miscompares, samples_checked, cyc_cnt} = '0;
		rst = 1'b1;
		cyc(6);
		rst = 1'b0;
		cyc(1);
		chk(lamps.fault, 1'b1);
		xcvr.refl_above = 1'b1;
		cyc(6);
		chk(pad, 1'b1);
		// long pulse with a good match: the cycle must outlive it
		xcvr.refl_above = 1'b0;
		xcvr.rf_present = 1'b1;
		xcvr.tune_request = 1'b1;
		cyc(5);
		chk(lamps.tuning, 1'b1);
		chk(lamps.fault, 1'b0);
		chk(cap_n, 1'b0);
		chk(ind_n, 1'b0);
		xcvr.channel_change_supply = 1'b1;
		cyc(10);
		xcvr.tune_request = 1'b0;
		cyc(4);
		chk(lamps.tuning, 1'b1);
		chk(lamps.fault, 1'b0);
		chk(cap_n, 1'b1);
		// short reflection spike restarts the qualification
		cyc(3);
		xcvr.refl_above = 1'b1;
		cyc(2);
		xcvr.refl_above = 1'b0;
		cyc(8);
		chk(lamps.tuning, 1'b1);
		wait_end(20);
		chk(lamps.ready, 1'b1);
		chk(lamps.fault, 1'b0);
		chk(pad, 1'b0);
		xcvr.channel_change_supply = 1'b0;
		at_max = 1'b1;
		cyc(6);
		chk(lamps.fault, 1'b0);
		chk(pad, 1'b1);
		at_max = 1'b0;
		xcvr.channel_change_supply = 1'b1;
		cyc(6);
		chk(lamps.fault, 1'b1);
		// tune held: pad re-insertion timer, cleared by a match pulse
		xcvr.tune_request = 1'b1;
		cyc(14);
		match = 1'b1;
		cyc(2);
		match = 1'b0;
		cyc(14);
		chk(pad, 1'b0);
		n = 0;
		while (pad !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		chk(pad, 1'b1);
		xcvr.tune_request = 1'b0;
		wait_end(40);
		// no rf, inductor forced on the first pass only: timeout ends the cycle
		frc = 1'b1;
		for (int i = 0; i < 2; i++) begin
			// rf at the start lets the pad drop; losing rf pulls it back
			xcvr.rf_present = 1'b1;
			xcvr.tune_request = 1'b1;
			cyc(3);
			chk(pad, 1'b1);
			xcvr.tune_request = 1'b0;
			xcvr.rf_present = 1'b0;
			cyc(3);
			chk(pad, 1'b1);
			wait_end(TO + 20);
			chk(logic'(n >= TO - 8 && n <= TO + 4), 1'b1);
			chk(lamps.fault, 1'b1);
			cyc(1);
			chk(pull_oe, logic'(i == 0));
			frc = 1'b0;
			cyc(10);
			chk(pull_oe, 1'b0);
		end
		opt_en = 1'b1;
		xcvr.tune_request = 1'b1;
		cyc(3);
		xcvr.tune_request = 1'b0;
		cyc(5);
		xcvr.nominal_supply_on = 1'b1;
		cyc(6);
		chk(lamps.tuning, 1'b0);
		chk(lamps.fault, 1'b1);
		final_report();
	end
endmodule
bind ctcl_top ctcl_top_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_prop (
	.clk(clk), .rst(rst), .xcvr(xcvr), .servo(servo),
	.opt_nominal_en(opt_nominal_en), .cap_home_request_n(cap_home_request_n),
	.ind_home_request_n(ind_home_request_n), .ind_at_max_n_o(ind_at_max_n_o),
	.ind_at_max_n_oe(ind_at_max_n_oe), .pad_relay(pad_relay), .lamps(lamps));
